// File: src/boost_cmd_seq.sv
// boost converter command sequencer: AXI4-Lite registers, timed
// unlock decode, stop and duty control, reset request, interrupt
// assumes analog status inputs are synchronous to mclk
//
// How it works
// - Converter runs with no firmware; software may only stop it or pick duty.
// - A decoded stop drives the converter from active into stopped.
// - A stop raises a pending reset request to the reset handler.
// - Battery rising above start while stopped restarts and clears reset request.
// - Command sequences begin with a power reduction write of 110x xxxx.
// - Second write 10xx xxxx within 3 cycles of the first.
// - Third write 01xx xxxx within 4 cycles decodes as stop.
// - Third write 111x xxxx within 4 cycles enables full duty cycle.
// - Full duty cycle bypasses regulation so output rises fastest.
// - A lone 111x xxxx write returns to regulated duty cycle.
// - Status flag reads one while switching, zero while idle or stopped.
// - After 11 then 10 writes, flag read within 5 cycles shows duty mode.
`timescale 1ns/1ns
module boost_cmd_seq (
  input  wire logic        mclk,             // 50 MHz system clock
  input  wire logic        rst_n,            // sync reset, active low
  input  wire logic [3:0]  awaddr,           // write address
  input  wire logic        awvalid,          // write address valid
  output logic             awready,          // write address ready
  input  wire logic [31:0] wdata,            // write data
  input  wire logic [3:0]  wstrb,            // write byte strobes
  input  wire logic        wvalid,           // write data valid
  output logic             wready,           // write data ready
  output logic [1:0]       bresp,            // write response
  output logic             bvalid,           // write response valid
  input  wire logic        bready,           // write response ready
  input  wire logic [3:0]  araddr,           // read address
  input  wire logic        arvalid,          // read address valid
  output logic             arready,          // read address ready
  output logic [31:0]      rdata,            // read data
  output logic [1:0]       rresp,            // read response
  output logic             rvalid,           // read data valid
  input  wire logic        rready,           // read data ready
  input  wire logic        conv_switching,   // power stage is switching
  input  wire logic        vbat_above_start, // battery above start level
  output logic             conv_stop,        // hold power stage stopped
  output logic             full_duty,        // lock duty cycle at maximum
  output logic             reset_req,        // pending reset request
  output logic             irq               // level interrupt
);

  typedef struct packed {
    logic                       awready;
    logic                       wready;
    logic                       aw_got;
    logic                       w_got;
    logic [3:0]                 aw_addr;
    logic [7:0]                 wbyte;
    logic                       wstrb0;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic [7:0]                 power_red;
    logic [boost_cmd_pkg::IRQ_W-1:0] irq_status;
    logic [boost_cmd_pkg::IRQ_W-1:0] irq_mask;
    boost_cmd_pkg::conv_state_t conv;
    logic                       conv_stop;
    logic                       reset_req;
    logic                       full_duty;
    logic                       vbat_q;
    logic                       irq;
  } top_state_t;

  top_state_t s;
  top_state_t n;

  logic wr_go;
  logic pr_wr;
  logic dec_stop;
  logic dec_fdc_on;
  logic dec_fdc_off;
  logic dec_abandon;
  logic dec_mode_sel;

  // ------------------------------------------------------------
  // write strobe into the sequence decoder
  // ------------------------------------------------------------
  // the decoder counts from the cycle the write lands, so the
  // unlock windows are measured at this point, not at the bus edge
  assign wr_go = s.aw_got && s.w_got && !s.bvalid;
  assign pr_wr = wr_go && s.wstrb0 && s.aw_addr == boost_cmd_pkg::OFS_POWER_RED;

  seq_decoder u_dec (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .wr_stb      (pr_wr),
    .wr_data     (s.wbyte),
    .cmd_stop    (dec_stop),
    .cmd_fdc_on  (dec_fdc_on),
    .cmd_fdc_off (dec_fdc_off),
    .abandon     (dec_abandon),
    .mode_sel    (dec_mode_sel)
  );

  // ------------------------------------------------------------
  // next state: bus slave, converter control, events
  // ------------------------------------------------------------
  always_comb
  begin
    logic [boost_cmd_pkg::IRQ_W-1:0] ev;
    logic                            flag;
    ev   = '0;
    flag = 1'b0;
    n    = s;

    // write channels taken in either order, held until response
    if (awvalid && s.awready)
    begin
      n.aw_got  = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && s.wready)
    begin
      n.w_got  = 1'b1;
      n.wbyte  = wdata[7:0];
      n.wstrb0 = wstrb[0];
    end
    if (wr_go)
    begin
      n.bvalid = 1'b1;
      n.bresp  = boost_cmd_pkg::RESP_OKAY;
      case (s.aw_addr)
        boost_cmd_pkg::OFS_POWER_RED:
          if (s.wstrb0)
            n.power_red = s.wbyte;
        boost_cmd_pkg::OFS_IRQ_MASK:
          if (s.wstrb0)
            n.irq_mask = s.wbyte[boost_cmd_pkg::IRQ_W-1:0];
        boost_cmd_pkg::OFS_ADC_STAT,
        boost_cmd_pkg::OFS_IRQ_STAT:
          n.bresp = boost_cmd_pkg::RESP_OKAY; // read-only, write ignored
        default:
          n.bresp = boost_cmd_pkg::RESP_SLVERR;
      endcase
    end
    if (s.bvalid && bready)
    begin
      n.bvalid = 1'b0;
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
    end

    // read channel: one read under way at a time
    if (s.rvalid && rready)
      n.rvalid = 1'b0;
    if (arvalid && s.arready)
    begin
      n.rvalid = 1'b1;
      n.rdata  = 32'h0000_0000;
      n.rresp  = boost_cmd_pkg::RESP_OKAY;
      // live switching flag, or duty mode inside the window
      flag = dec_mode_sel ? s.full_duty : conv_switching;
      case (araddr)
        boost_cmd_pkg::OFS_POWER_RED:
          n.rdata[7:0] = s.power_red;
        boost_cmd_pkg::OFS_ADC_STAT:
          n.rdata[boost_cmd_pkg::FLAG_BIT] = flag;
        boost_cmd_pkg::OFS_IRQ_STAT:
        begin
          n.rdata[boost_cmd_pkg::IRQ_W-1:0] = s.irq_status;
          n.irq_status = '0;
        end
        boost_cmd_pkg::OFS_IRQ_MASK:
          n.rdata[boost_cmd_pkg::IRQ_W-1:0] = s.irq_mask;
        default:
          n.rresp = boost_cmd_pkg::RESP_SLVERR;
      endcase
    end

    // converter run/stop control
    // from reset the converter runs with no software action
    n.vbat_q = vbat_above_start;
    case (s.conv)
      boost_cmd_pkg::CONV_RUN:
        if (dec_stop)
        begin
          // leave active mode for stop mode
          n.conv      = boost_cmd_pkg::CONV_STOPPED;
          n.conv_stop = 1'b1;
          // stop also raises the reset request
          n.reset_req = 1'b1;
          ev[boost_cmd_pkg::IRQ_STOP] = 1'b1;
        end
      boost_cmd_pkg::CONV_STOPPED:
        // battery recovery restarts and withdraws the reset request
        if (vbat_above_start && !s.vbat_q)
        begin
          n.conv      = boost_cmd_pkg::CONV_RUN;
          n.conv_stop = 1'b0;
          n.reset_req = 1'b0;
          ev[boost_cmd_pkg::IRQ_RESTART] = 1'b1;
        end
      default:
        n.conv = boost_cmd_pkg::CONV_RUN;
    endcase

    // duty cycle control method
    // full duty bypasses the regulator in the power stage
    if (dec_fdc_on)
      n.full_duty = 1'b1;
    else if (dec_fdc_off)
      n.full_duty = 1'b0;
    ev[boost_cmd_pkg::IRQ_FDC_ON]  = dec_fdc_on;
    ev[boost_cmd_pkg::IRQ_FDC_OFF] = dec_fdc_off;
    ev[boost_cmd_pkg::IRQ_ABANDON] = dec_abandon;

    // sticky events: a set in the clearing read cycle survives
    n.irq_status = n.irq_status | ev;
    n.irq        = |(n.irq_status & n.irq_mask);

    // ready only while the channel slot is free
    n.awready = !n.aw_got;
    n.wready  = !n.w_got;
    n.arready = !n.rvalid;
  end

  // ------------------------------------------------------------
  // registered state
  // ------------------------------------------------------------
  // ready outputs sit low during reset and rise one edge after
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s           <= '0;
      s.power_red <= boost_cmd_pkg::PR_RESET;
      s.conv      <= boost_cmd_pkg::CONV_RUN;
    end
    else
      s <= n;
  end

  assign awready   = s.awready;
  assign wready    = s.wready;
  assign bvalid    = s.bvalid;
  assign bresp     = s.bresp;
  assign arready   = s.arready;
  assign rvalid    = s.rvalid;
  assign rdata     = s.rdata;
  assign rresp     = s.rresp;
  assign conv_stop = s.conv_stop;
  assign full_duty = s.full_duty;
  assign reset_req = s.reset_req;
  assign irq       = s.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking tcb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  no_self_stop_a: assert property (
    $rose(conv_stop) |-> $past(dec_stop))
    else $error("converter stopped without a command");

  stop_enter_a: assert property (
    dec_stop && s.conv == boost_cmd_pkg::CONV_RUN
    |=> conv_stop && s.conv == boost_cmd_pkg::CONV_STOPPED)
    else $error("stop command did not stop converter");

  reset_raise_a: assert property (
    $rose(conv_stop) |-> reset_req ##1 reset_req || !conv_stop)
    else $error("stop without reset request");

  restart_clear_a: assert property (
    conv_stop && vbat_above_start && !s.vbat_q |=> !reset_req && !conv_stop)
    else $error("restart did not clear reset request");

  fdc_on_a: assert property (
    dec_fdc_on |=> full_duty [*2] or ##1 (full_duty ##1 dec_fdc_off))
    else $error("full duty not applied");

  fdc_off_a: assert property (
    dec_fdc_off && !dec_fdc_on |=> !full_duty)
    else $error("regulated duty not restored");

  flag_read_a: assert property (
    arvalid && arready && araddr == boost_cmd_pkg::OFS_ADC_STAT && !dec_mode_sel
    |=> rvalid && rdata[boost_cmd_pkg::FLAG_BIT] == $past(conv_switching))
    else $error("status flag not the switching state");

  mode_read_a: assert property (
    arvalid && arready && araddr == boost_cmd_pkg::OFS_ADC_STAT && dec_mode_sel
    |=> rdata[boost_cmd_pkg::FLAG_BIT] == $past(full_duty))
    else $error("status flag not the duty mode");

  stop_cover_c: cover property ($rose(conv_stop));
  restart_cover_c: cover property ($fell(reset_req));
  fdc_cover_c: cover property ($rose(full_duty) ##[1:50] $fell(full_duty));
  irq_cover_c: cover property ($rose(irq));

endmodule // boost_cmd_seq

// File: src/boost_cmd_pkg.sv
// constants and types shared by the boost converter command sequencer
// assumes a 50 MHz mclk and a 4-bit AXI4-Lite byte address
package boost_cmd_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [3:0] OFS_POWER_RED = 4'h0;  // power_reduction_reg
  localparam logic [3:0] OFS_ADC_STAT  = 4'h4;  // converter_adc_status_reg
  localparam logic [3:0] OFS_IRQ_STAT  = 4'h8;  // event flags, read clears
  localparam logic [3:0] OFS_IRQ_MASK  = 4'hC;  // event enables

  // ------------------------------------------------------------
  // fields, patterns and reset values
  // ------------------------------------------------------------
  localparam int          FLAG_BIT     = 7;     // converter_switching_flag
  localparam logic [2:0]  TOP3_UNLOCK  = 3'h6;  // 110x xxxx
  localparam logic [2:0]  TOP3_FDC     = 3'h7;  // 111x xxxx
  localparam logic [1:0]  TOP2_ARM     = 2'h3;  // 11xx xxxx
  localparam logic [1:0]  TOP2_STEP2   = 2'h2;  // 10xx xxxx
  localparam logic [1:0]  TOP2_STOP    = 2'h1;  // 01xx xxxx
  localparam int          IRQ_W        = 5;
  localparam int          IRQ_STOP     = 0;
  localparam int          IRQ_RESTART  = 1;
  localparam int          IRQ_FDC_ON   = 2;
  localparam int          IRQ_FDC_OFF  = 3;
  localparam int          IRQ_ABANDON  = 4;
  localparam logic [7:0]  PR_RESET     = 8'h00;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ------------------------------------------------------------
  // sequence windows in mclk cycles after the first write
  // ------------------------------------------------------------
  localparam logic [2:0]  WIN_STEP2    = 3'h3;
  localparam logic [2:0]  WIN_STEP3    = 3'h4;
  localparam logic [2:0]  WIN_READ     = 3'h5;
  localparam logic [2:0]  CNT_MAX      = 3'h7;

  typedef enum logic [2:0] {
    SEQ_IDLE     = 3'b001,
    SEQ_ARMED    = 3'b010,
    SEQ_UNLOCKED = 3'b100
  } seq_state_t;

  typedef enum logic [1:0] {
    CONV_RUN     = 2'b01,
    CONV_STOPPED = 2'b10
  } conv_state_t;

endpackage

// File: src/seq_decoder.sv
// timed write-sequence decoder for the power reduction register
// assumes one wr_stb pulse per register write, synchronous to mclk
`timescale 1ns/1ns
module seq_decoder (
  input  wire logic       mclk,        // system clock
  input  wire logic       rst_n,       // sync reset, active low
  input  wire logic       wr_stb,      // power reduction write this cycle
  input  wire logic [7:0] wr_data,     // value written
  output logic            cmd_stop,    // pulse: stop command
  output logic            cmd_fdc_on,  // pulse: full duty cycle on
  output logic            cmd_fdc_off, // pulse: back to regulated duty
  output logic            abandon,     // pulse: unlock sequence dropped
  output logic            mode_sel     // status bit shows duty mode
);

  typedef struct packed {
    boost_cmd_pkg::seq_state_t state;
    logic [2:0]                cnt;
    logic                      lock110;
    logic                      stop;
    logic                      fdc_on;
    logic                      fdc_off;
    logic                      drop;
  } dec_state_t;

  dec_state_t s;
  dec_state_t n;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // a mismatching write is re-read as a fresh first write, so a
  // new sequence started early is not lost
  always_comb
  begin
    logic fresh;
    fresh     = 1'b0;
    n         = s;
    n.stop    = 1'b0;
    n.fdc_on  = 1'b0;
    n.fdc_off = 1'b0;
    n.drop    = 1'b0;
    if (s.state != boost_cmd_pkg::SEQ_IDLE && s.cnt != boost_cmd_pkg::CNT_MAX)
      n.cnt = s.cnt + 3'h1;
    case (s.state)
      boost_cmd_pkg::SEQ_IDLE:
        fresh = wr_stb;
      boost_cmd_pkg::SEQ_ARMED:
        if (wr_stb && wr_data[7:6] == boost_cmd_pkg::TOP2_STEP2
            && s.cnt < boost_cmd_pkg::WIN_STEP2)
          n.state = boost_cmd_pkg::SEQ_UNLOCKED;
        else if (wr_stb || s.cnt >= boost_cmd_pkg::WIN_STEP2)
        begin
          // abandon a late or wrong step
          n.state = boost_cmd_pkg::SEQ_IDLE;
          n.drop  = s.lock110;
          fresh   = wr_stb;
        end
      boost_cmd_pkg::SEQ_UNLOCKED:
        if (wr_stb && s.lock110 && s.cnt < boost_cmd_pkg::WIN_STEP3
            && wr_data[7:6] == boost_cmd_pkg::TOP2_STOP)
        begin
          n.stop  = 1'b1;
          n.state = boost_cmd_pkg::SEQ_IDLE;
        end
        else if (wr_stb && s.lock110 && s.cnt < boost_cmd_pkg::WIN_STEP3
                 && wr_data[7:5] == boost_cmd_pkg::TOP3_FDC)
        begin
          n.fdc_on = 1'b1;
          n.state  = boost_cmd_pkg::SEQ_IDLE;
        end
        else if (wr_stb || s.cnt >= boost_cmd_pkg::WIN_READ)
        begin
          n.state = boost_cmd_pkg::SEQ_IDLE;
          n.drop  = s.lock110;
          fresh   = wr_stb;
        end
      default:
        n.state = boost_cmd_pkg::SEQ_IDLE;
    endcase
    if (fresh)
    begin
      n.fdc_off = wr_data[7:5] == boost_cmd_pkg::TOP3_FDC;
      // an 11 write arms; 110 allows commands
      if (wr_data[7:6] == boost_cmd_pkg::TOP2_ARM)
      begin
        n.state   = boost_cmd_pkg::SEQ_ARMED;
        n.cnt     = 3'h0;
        n.lock110 = wr_data[7:5] == boost_cmd_pkg::TOP3_UNLOCK;
      end
    end
  end

  // registered state
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s       <= '0;
      s.state <= boost_cmd_pkg::SEQ_IDLE;
    end
    else
      s <= n;
  end

  assign cmd_stop    = s.stop;
  assign cmd_fdc_on  = s.fdc_on;
  assign cmd_fdc_off = s.fdc_off;
  assign abandon     = s.drop;
  // read window runs to cycle 5 after the first write
  assign mode_sel    = s.state == boost_cmd_pkg::SEQ_UNLOCKED
                       && s.cnt < boost_cmd_pkg::WIN_READ;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  unlock_start_a: assert property (
    s.state == boost_cmd_pkg::SEQ_IDLE && wr_stb
    && wr_data[7:5] == boost_cmd_pkg::TOP3_UNLOCK
    |=> s.state == boost_cmd_pkg::SEQ_ARMED && s.lock110)
    else $error("110 write did not arm the sequence");

  step2_timeout_a: assert property (
    s.state == boost_cmd_pkg::SEQ_IDLE && wr_stb
    && wr_data[7:6] == boost_cmd_pkg::TOP2_ARM
    ##1 !wr_stb [*4] |=> s.state == boost_cmd_pkg::SEQ_IDLE)
    else $error("armed sequence outlived its window");

  stop_decode_a: assert property (
    cmd_stop |-> $past(s.state == boost_cmd_pkg::SEQ_UNLOCKED && s.lock110
    && s.cnt < boost_cmd_pkg::WIN_STEP3 && wr_stb))
    else $error("stop decoded outside its window");

  fdc_decode_a: assert property (
    cmd_fdc_on |-> $past(wr_data[7:5]) == boost_cmd_pkg::TOP3_FDC
    && $past(s.state) == boost_cmd_pkg::SEQ_UNLOCKED)
    else $error("full duty decoded from wrong write");

  normal_cmd_a: assert property (
    s.state == boost_cmd_pkg::SEQ_IDLE && wr_stb
    && wr_data[7:5] == boost_cmd_pkg::TOP3_FDC |=> cmd_fdc_off)
    else $error("standalone 111 write ignored");

  wrong_step_a: assert property (
    s.state == boost_cmd_pkg::SEQ_ARMED && s.lock110 && wr_stb
    && wr_data[7:6] != boost_cmd_pkg::TOP2_STEP2 |=> abandon ##1 !cmd_stop)
    else $error("bad second step not abandoned");

endmodule // seq_decoder

// File: tb/boost_stage_model.sv
// power stage and battery model facing the sequencer
// assumes mclk domain; charger_on comes from the bench
`timescale 1ns/1ns
module boost_stage_model (
  input  wire logic mclk,             // system clock
  input  wire logic rst_n,            // sync reset, active low
  input  wire logic conv_stop,        // stop hold from dut
  input  wire logic full_duty,        // duty lock from dut
  input  wire logic charger_on,       // bench attaches a charger
  output logic      conv_switching,   // stage is switching
  output logic      vbat_above_start  // battery above start level
);
  logic [2:0] phase;

  // ------------------------------------------------------------
  // low current mode pattern
  // ------------------------------------------------------------
  // never switches while stopped
  // full duty charges faster, so the switching part of a period is shorter
  always_ff @(posedge mclk)
  begin
    phase <= rst_n ? phase + 3'h1 : 3'h0;
    conv_switching <= rst_n && !conv_stop && (phase < (full_duty ? 3'h2 : 3'h5));
    vbat_above_start <= rst_n && charger_on;
  end
endmodule // boost_stage_model

// File: tb/boost_converter_command_sequencer_tb_top.sv
// self-checking bench for the boost converter command sequencer
// assumes the stage model and the design files are compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module boost_converter_command_sequencer_tb_top;
  logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, charger_on;
  logic        awready, wready, bvalid, arready, rvalid, sw, ok, stopped;
  logic        conv_switching, vbat_above_start, conv_stop, full_duty, reset_req, irq;
  logic [3:0]  awaddr, wstrb, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] lfsr;
  logic [7:0]  v;
  int          fail_count, checked, cyc, t, t1, t2, i;

  // ------------------------------------------------------------
  // clock, cycle count, timeout
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  boost_cmd_seq dut_u (.mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .conv_switching(conv_switching), .vbat_above_start(vbat_above_start),
    .conv_stop(conv_stop), .full_duty(full_duty), .reset_req(reset_req), .irq(irq));
  boost_stage_model stage_u (.mclk(mclk), .rst_n(rst_n), .conv_stop(conv_stop),
    .full_duty(full_duty), .charger_on(charger_on), .conv_switching(conv_switching),
    .vbat_above_start(vbat_above_start));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // write; t is the edge where bvalid is seen, one after the write lands
  task automatic wr(input logic [3:0] a, input logic [7:0] x, output logic [1:0] q,
                    output int tt);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, x};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge mclk);
      if (!ta && awready) begin ta = 1'b1; awvalid <= 1'b0; end
      if (!tw && wready) begin tw = 1'b1; wvalid <= 1'b0; end
    end
    bready <= 1'b1;
    do @(posedge mclk); while (!bvalid);
    q = bresp;
    tt = cyc;
    bready <= 1'b0;
  endtask
  // read; tt and s are taken at the address handshake edge
  task automatic rd(input logic [3:0] a, output logic [31:0] x, output int tt,
                    output logic s);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (!arready);
    tt = cyc;
    s = conv_switching;
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    x = rdata;
    rready <= 1'b0;
    @(posedge mclk);
  endtask
  // unlock pair then a third write; ok tells whether both windows were met
  task automatic cmd_seq(input logic [7:0] x3, output logic k);
    int a, b, c;
    lfsr = next_rand(lfsr);
    wr(boost_cmd_pkg::OFS_POWER_RED, {boost_cmd_pkg::TOP3_UNLOCK, lfsr[4:0]}, r, a);
    wr(boost_cmd_pkg::OFS_POWER_RED, {boost_cmd_pkg::TOP2_STEP2, lfsr[9:4]}, r, b);
    wr(boost_cmd_pkg::OFS_POWER_RED, x3, r, c);
    k = (b - a <= 3) && (c - a <= 4);
    repeat (3) @(posedge mclk);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, charger_on} = '0;
    {awaddr, araddr, wstrb, wdata} = '0;
    fail_count = 0;
    checked = 0;
    cyc = 0;
    lfsr = 16'h0B1C;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(boost_cmd_pkg::OFS_POWER_RED, d, t, sw);
    `CHK(d, 32'h00000000)
    `CHK({conv_stop, full_duty, reset_req, irq}, 4'h0)
    // random plain values never open a sequence and read back as written
    for (i = 0; i < 6; i++)
    begin
      lfsr = next_rand(lfsr);
      v = {1'b0, lfsr[6:0]};
      wr(boost_cmd_pkg::OFS_POWER_RED, v, r, t);
      rd(boost_cmd_pkg::OFS_POWER_RED, d, t, sw);
      `CHK(d, {24'h000000, v})
    end
    wr(4'h2, 8'h00, r, t);
    `CHK(r, boost_cmd_pkg::RESP_SLVERR)
    cmd_seq({boost_cmd_pkg::TOP3_FDC, lfsr[4:0]}, ok);
    `CHK(full_duty, ok)
    rd(boost_cmd_pkg::OFS_IRQ_STAT, d, t, sw);
    `CHK({d[boost_cmd_pkg::IRQ_FDC_ON], d[boost_cmd_pkg::IRQ_ABANDON]}, {ok, !ok})
    // lone write while masked, then unmask: interrupt follows the sticky bit
    wr(boost_cmd_pkg::OFS_POWER_RED, {boost_cmd_pkg::TOP3_FDC, lfsr[7:3]}, r, t);
    repeat (3) @(posedge mclk);
    `CHK({full_duty, irq}, 2'h0)
    wr(boost_cmd_pkg::OFS_IRQ_MASK, 8'h1F, r, t);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b1)
    rd(boost_cmd_pkg::OFS_IRQ_STAT, d, t, sw);
    repeat (2) @(posedge mclk);
    `CHK({d[boost_cmd_pkg::IRQ_FDC_OFF], irq}, 2'h2)
    cmd_seq({boost_cmd_pkg::TOP2_STOP, lfsr[5:0]}, stopped);
    `CHK({conv_stop, reset_req}, {stopped, stopped})
    rd(boost_cmd_pkg::OFS_IRQ_STAT, d, t, sw);
    `CHK({d[boost_cmd_pkg::IRQ_STOP], d[boost_cmd_pkg::IRQ_ABANDON]}, {stopped, !stopped})
    // firmware polls the switching flag instead of waiting for reset
    // brown-out guard sits outside this block; the bench keeps supply up
    for (i = 0; i < 4; i++)
    begin
      lfsr = next_rand(lfsr);
      repeat (lfsr[2:0]) @(posedge mclk);
      rd(boost_cmd_pkg::OFS_ADC_STAT, d, t, sw);
      `CHK(d, {24'h000000, sw, 7'h00})
    end
    charger_on <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK({conv_stop, reset_req}, 2'h0)
    rd(boost_cmd_pkg::OFS_IRQ_STAT, d, t, sw);
    `CHK(d[boost_cmd_pkg::IRQ_RESTART], stopped)
    charger_on <= 1'b0;
    // mode read straight after the unlock pair
    wr(boost_cmd_pkg::OFS_POWER_RED, 8'hC0, r, t1);
    wr(boost_cmd_pkg::OFS_POWER_RED, 8'h80, r, t2);
    rd(boost_cmd_pkg::OFS_ADC_STAT, d, t, sw);
    ok = (t2 - t1 <= 3) && (t - t1 + 1 <= 5);
    `CHK(d[boost_cmd_pkg::FLAG_BIT], ok ? full_duty : sw)
    tally_and_finish();
  end
endmodule // boost_converter_command_sequencer_tb_top
